// >>> include/jfst_defines.vh
// Purpose: Register map, field positions, reset values and codes
// Assumes: 32-bit Wishbone word registers at byte offsets
// Notes:   Definitions only
`ifndef JFST_DEFINES_VH
`define JFST_DEFINES_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define JFST_ADR_SEL   8'h00
`define JFST_ADR_CFG   8'h04
`define JFST_ADR_TEST  8'h08
`define JFST_ADR_GATE  8'h0C
`define JFST_ADR_STAT  8'h10

// ----------------------------------------------------------------------
// Configuration fields
// ----------------------------------------------------------------------
`define JFST_CFG_OVERSAMPLE 0
`define JFST_CFG_MANUAL     1
`define JFST_CFG_ROUTE_LSB  2
`define JFST_CFG_DIFF       10
`define JFST_CFG_FLIP       11
`define JFST_CFG_REALIGN    12
`define JFST_CFG_WAIT       13
`define JFST_CFG_SKIP_EN    14
`define JFST_CFG_SKIP_LSB   15
`define JFST_CFG_DROP       19
`define JFST_CFG_SYNC_LSB   20
`define JFST_CFG_W          22

// ----------------------------------------------------------------------
// Test, gate and status fields
// ----------------------------------------------------------------------
`define JFST_TEST_SRC_LSB   0
`define JFST_TEST_INJ_LSB   4
`define JFST_TEST_WORD_LSB  16
`define JFST_GATE_EN_BIT    8
`define JFST_ST_ALIGNED     0
`define JFST_ST_PHASE_ERR   1
`define JFST_ST_CGS         2
`define JFST_ST_SYNC        3

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define JFST_SEL_RST   3'h7
`define JFST_GATE_RST  3'h7
`define JFST_CFG_RST   22'h00_0000
`define JFST_TEST_RST  32'h0000_0000

// ----------------------------------------------------------------------
// Data sources and injection points
// ----------------------------------------------------------------------
`define JFST_SRC_CONV     4'h0
`define JFST_SRC_CHECKER  4'h1
`define JFST_SRC_TOGGLE   4'h2
`define JFST_SRC_PRBS31   4'h3
`define JFST_SRC_PRBS23   4'h4
`define JFST_SRC_PRBS15   4'h5
`define JFST_SRC_PRBS9    4'h6
`define JFST_SRC_PRBS7    4'h7
`define JFST_SRC_RAMP     4'h8
`define JFST_SRC_LOOP     4'h9
`define JFST_SRC_SINGLE   4'hA
`define JFST_INJ_FRONT    2'h0
`define JFST_INJ_SERDES   2'h1
`define JFST_INJ_ROUTE    2'h2
`define JFST_CHECKER_WORD 16'hAAAA
`define JFST_PRBS_SEED    31'h7FFF_FFFF

`endif

// >>> core/jfst_framer_ctrl.v
// Purpose: Framer control for up to three transmit framers
// Assumes: Wishbone classic slave, one clock, link_up_i on same clock
// Notes:   Lanes are four 4-bit nibbles of a 16-bit word per framer
//
// Implementation choices: the Wishbone slave port and the register addresses.
`timescale 1ns/100ps
`include "jfst_defines.vh"

module jfst_framer_ctrl #(
  parameter         NFR         = 3,
  parameter [7:0]   LMFC_PERIOD = 8'h20,
  parameter [7:0]   LEMC_PERIOD = 8'h80
) (
  input  wire             clk_i,
  input  wire             rst_i,
  input  wire             wb_cyc_i,
  input  wire             wb_stb_i,
  input  wire             wb_we_i,
  input  wire [7:0]       wb_adr_i,
  input  wire [3:0]       wb_sel_i,
  input  wire [31:0]      wb_dat_i,
  output wire [31:0]      wb_dat_o,
  output wire             wb_ack_o,
  input  wire             sysref_pin_i,
  input  wire             mcs_done_i,
  input  wire [NFR-1:0]   link_up_i,
  input  wire [NFR-1:0]   pad_required_i,
  input  wire [2:0]       sync_cmos_i,
  input  wire [2:0]       sync_lvds_i,
  input  wire [NFR*16-1:0] conv_data_i,
  output wire [NFR*16-1:0] lane_data_o,
  output wire [NFR-1:0]   lmfc_pulse_o,
  output wire [NFR-1:0]   lemc_pulse_o,
  output wire [NFR-1:0]   cgs_enable_o,
  output wire [NFR-1:0]   bit_repeat_o,
  output wire [NFR-1:0]   oversample_o
);

  localparam [7:0] LMFC_LAST = LMFC_PERIOD - 8'h01;
  localparam [7:0] LEMC_LAST = LEMC_PERIOD - 8'h01;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function [31:0] bmerge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  sel;
    integer b;
    begin
      bmerge = old_v;
      for (b = 0; b < 4; b = b + 1) begin
        if (sel[b])
          bmerge[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
  endfunction

  // Sixteen PRBS steps per word; returns {word, state}
  function [46:0] prbs16;
    input [30:0] s;
    input [3:0]  code;
    reg   [30:0] t;
    reg   [15:0] w;
    reg          fb;
    integer k;
    begin
      t = s;
      w = 16'h0000;
      for (k = 0; k < 16; k = k + 1) begin
        case (code)
          `JFST_SRC_PRBS31: fb = t[30] ^ t[27];
          `JFST_SRC_PRBS23: fb = t[22] ^ t[17];
          `JFST_SRC_PRBS15: fb = t[14] ^ t[13];
          `JFST_SRC_PRBS9:  fb = t[8] ^ t[4];
          default:          fb = t[6] ^ t[5];
        endcase
        t = {t[29:0], fb};
        w = {w[14:0], fb};
      end
      prbs16 = {w, t};
    end
  endfunction

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  reg [2:0] sr_sync_reg;
  reg [2:0] cmos_s1_reg;
  reg [2:0] cmos_s2_reg;
  reg [2:0] lvds_s1_reg;
  reg [2:0] lvds_s2_reg;
  wire      sr_edge;

  always @(posedge clk_i) begin
    if (rst_i) begin
      sr_sync_reg <= 3'h0;
      cmos_s1_reg <= 3'h0;
      cmos_s2_reg <= 3'h0;
      lvds_s1_reg <= 3'h0;
      lvds_s2_reg <= 3'h0;
    end else begin
      sr_sync_reg <= {sr_sync_reg[1:0], sysref_pin_i};
      cmos_s1_reg <= sync_cmos_i;
      cmos_s2_reg <= cmos_s1_reg;
      lvds_s1_reg <= sync_lvds_i;
      lvds_s2_reg <= lvds_s1_reg;
    end
  end

  assign sr_edge = sr_sync_reg[1] & ~sr_sync_reg[2];

  // ----------------------------------------------------------------------
  // Wishbone slave and shared registers
  // ----------------------------------------------------------------------
  reg  [NFR-1:0]   sel_reg;
  reg  [NFR-1:0]   gate_reg;
  reg              ack_reg;
  reg  [31:0]      dat_reg;
  reg  [31:0]      rd_next;
  reg  [NFR-1:0]   gate_next;
  wire             wr;
  wire             wr_cfg;
  wire             wr_test;
  wire             wr_stat;
  wire [NFR*32-1:0] cfg_all;
  wire [NFR*32-1:0] test_all;
  wire [NFR*4-1:0]  stat_all;
  wire [NFR-1:0]    gate_mask;
  integer          ri;
  integer          rd_idx;

  assign wr      = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_reg;
  assign wr_cfg  = wr & (wb_adr_i == `JFST_ADR_CFG);
  assign wr_test = wr & (wb_adr_i == `JFST_ADR_TEST);
  assign wr_stat = wr & (wb_adr_i == `JFST_ADR_STAT);
  assign gate_mask = wb_dat_i[NFR-1:0];

  always @* begin
    gate_next = gate_reg;
    if (wr && wb_adr_i == `JFST_ADR_GATE && wb_sel_i[0] && wb_sel_i[1]) begin
      if (wb_dat_i[`JFST_GATE_EN_BIT])
        gate_next = gate_reg | gate_mask;
      else
        gate_next = gate_reg & ~gate_mask;
    end
  end

  always @* begin
    rd_idx = 0;
    for (ri = NFR - 1; ri >= 0; ri = ri - 1) begin
      if (sel_reg[ri])
        rd_idx = ri;
    end
    rd_next = 32'h0000_0000;
    case (wb_adr_i)
      `JFST_ADR_SEL:  rd_next[NFR-1:0] = sel_reg;
      `JFST_ADR_CFG:  rd_next = cfg_all[rd_idx*32 +: 32];
      `JFST_ADR_TEST: rd_next = test_all[rd_idx*32 +: 32];
      `JFST_ADR_GATE: rd_next[NFR-1:0] = gate_reg;
      `JFST_ADR_STAT: rd_next[NFR*4-1:0] = stat_all;
      default:        rd_next = 32'h0000_0000;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      sel_reg  <= `JFST_SEL_RST;
      gate_reg <= `JFST_GATE_RST;
      ack_reg  <= 1'b0;
      dat_reg  <= 32'h0000_0000;
    end else begin
      ack_reg  <= wb_cyc_i & wb_stb_i & ~ack_reg;
      dat_reg  <= rd_next;
      gate_reg <= gate_next;
      if (wr && wb_adr_i == `JFST_ADR_SEL && wb_sel_i[0])
        sel_reg <= wb_dat_i[NFR-1:0];
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;

  // ----------------------------------------------------------------------
  // Per-framer logic
  // ----------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < NFR; i = i + 1) begin : fr
      reg  [`JFST_CFG_W-1:0] cfg_reg;
      reg  [31:0] test_reg;
      reg  [3:0]  skip_cnt_reg;
      reg         aligned_reg;
      reg         perr_reg;
      reg  [7:0]  lmfc_cnt_reg;
      reg  [7:0]  lemc_cnt_reg;
      reg         link_d_reg;
      reg         gate_d_reg;
      reg         lmfc_p_reg;
      reg         lemc_p_reg;
      reg         cgs_reg;
      reg         sync_lvl_reg;
      reg         brep_reg;
      reg         ovs_reg;
      reg  [30:0] prbs_reg;
      reg  [15:0] ramp_reg;
      reg         tog_reg;
      reg         once_reg;
      reg  [15:0] mid_reg;
      reg  [15:0] lane_reg;
      reg  [15:0] gen;
      reg  [15:0] routed;
      reg  [1:0]  pick;
      reg         sync_mux;
      integer     j;
      wire [31:0] cfg_wide;
      wire [31:0] cfg_merge;
      wire [46:0] prbs_nx;
      wire [3:0]  src;
      wire [1:0]  inj;
      wire        test_on;
      wire        at_serdes;
      wire        at_route;
      wire        at_front;
      wire [15:0] front;
      wire        link_up;
      wire        link_rise;
      wire        gate_rise;
      wire        q_edge;
      wire        align;
      wire [3:0]  target;
      wire        sel_me;
      wire        perr_clr;
      wire [1:0]  sync_sel;

      assign sel_me   = sel_reg[i];
      assign cfg_wide = {{(32-`JFST_CFG_W){1'b0}}, cfg_reg};
      assign cfg_merge = bmerge(cfg_wide, wb_dat_i, wb_sel_i);
      assign src      = test_reg[`JFST_TEST_SRC_LSB +: 4];
      assign inj      = test_reg[`JFST_TEST_INJ_LSB +: 2];
      assign link_up  = link_up_i[i];
      assign link_rise = link_up & ~link_d_reg;
      assign gate_rise = gate_reg[i] & ~gate_d_reg;

      assign q_edge = sr_edge & gate_reg[i] & mcs_done_i &
                      ~(cfg_reg[`JFST_CFG_DROP] & link_up);

      assign target = cfg_reg[`JFST_CFG_SKIP_EN] ?
                      cfg_reg[`JFST_CFG_SKIP_LSB +: 4] : 4'h0;
      assign align  = q_edge & ~aligned_reg & (skip_cnt_reg == target);

      assign perr_clr = wr_stat & wb_sel_i[0] &
                        wb_dat_i[i*4 + `JFST_ST_PHASE_ERR];

      always @(posedge clk_i) begin
        if (rst_i) begin
          cfg_reg  <= `JFST_CFG_RST;
          test_reg <= `JFST_TEST_RST;
        end else begin
          if (wr_cfg && sel_me)
            cfg_reg <= cfg_merge[`JFST_CFG_W-1:0];
          if (wr_test && sel_me)
            test_reg <= bmerge(test_reg, wb_dat_i, wb_sel_i);
        end
      end

      always @(posedge clk_i) begin
        if (rst_i) begin
          skip_cnt_reg <= 4'h0;
          aligned_reg  <= 1'b0;
          perr_reg     <= 1'b0;
          lmfc_cnt_reg <= 8'h00;
          lemc_cnt_reg <= 8'h00;
          link_d_reg   <= 1'b0;
          gate_d_reg   <= 1'b0;
          lmfc_p_reg   <= 1'b0;
          lemc_p_reg   <= 1'b0;
          cgs_reg      <= 1'b0;
        end else begin
          link_d_reg <= link_up;
          gate_d_reg <= gate_reg[i];
          if (gate_rise || link_rise)
            skip_cnt_reg <= 4'h0;
          else if (q_edge && !aligned_reg && !align &&
                   skip_cnt_reg != 4'hF)
            skip_cnt_reg <= skip_cnt_reg + 4'h1;
          if (link_rise && cfg_reg[`JFST_CFG_REALIGN])
            aligned_reg <= 1'b0;
          else if (align)
            aligned_reg <= 1'b1;
          if (q_edge && aligned_reg && lmfc_cnt_reg != 8'h00)
            perr_reg <= 1'b1;
          else if (perr_clr)
            perr_reg <= 1'b0;
          if (align) begin
            lmfc_cnt_reg <= 8'h01;
            lemc_cnt_reg <= 8'h01;
          end else begin
            lmfc_cnt_reg <= (lmfc_cnt_reg == LMFC_LAST) ? 8'h00 :
                            lmfc_cnt_reg + 8'h01;
            lemc_cnt_reg <= (lemc_cnt_reg == LEMC_LAST) ? 8'h00 :
                            lemc_cnt_reg + 8'h01;
          end
          lmfc_p_reg <= aligned_reg & (lmfc_cnt_reg == LMFC_LAST);
          lemc_p_reg <= aligned_reg & (lemc_cnt_reg == LEMC_LAST);
          cgs_reg <= cfg_reg[`JFST_CFG_WAIT] ? aligned_reg : 1'b1;
        end
      end

      // ------------------------------------------------------------------
      // Sync input receiver
      // ------------------------------------------------------------------
      assign sync_sel = cfg_reg[`JFST_CFG_SYNC_LSB +: 2];

      always @* begin
        case (sync_sel)
          2'h1: pick = 2'h1;
          2'h2: pick = 2'h2;
          default: pick = 2'h0;
        endcase
        if (cfg_reg[`JFST_CFG_DIFF])
          sync_mux = lvds_s2_reg[pick] ^ cfg_reg[`JFST_CFG_FLIP];
        else
          sync_mux = cmos_s2_reg[pick];
      end

      always @(posedge clk_i) begin
        if (rst_i) begin
          sync_lvl_reg <= 1'b0;
          brep_reg     <= 1'b0;
          ovs_reg      <= 1'b0;
        end else begin
          sync_lvl_reg <= sync_mux;
          brep_reg <= pad_required_i[i] & ~cfg_reg[`JFST_CFG_OVERSAMPLE];
          ovs_reg  <= pad_required_i[i] & cfg_reg[`JFST_CFG_OVERSAMPLE];
        end
      end

      // ------------------------------------------------------------------
      // Test data generator
      // ------------------------------------------------------------------
      assign prbs_nx = prbs16(prbs_reg, src);

      always @* begin
        case (src)
          `JFST_SRC_CONV:    gen = conv_data_i[i*16 +: 16];
          `JFST_SRC_CHECKER: gen = `JFST_CHECKER_WORD;
          `JFST_SRC_TOGGLE:  gen = {16{tog_reg}};
          `JFST_SRC_PRBS31,
          `JFST_SRC_PRBS23,
          `JFST_SRC_PRBS15,
          `JFST_SRC_PRBS9,
          `JFST_SRC_PRBS7:   gen = prbs_nx[46:31];
          `JFST_SRC_RAMP:    gen = ramp_reg;
          `JFST_SRC_LOOP:    gen = test_reg[`JFST_TEST_WORD_LSB +: 16];
          `JFST_SRC_SINGLE:  gen = once_reg ? 16'h0000 :
                                   test_reg[`JFST_TEST_WORD_LSB +: 16];
          default:           gen = 16'h0000;
        endcase
      end

      always @(posedge clk_i) begin
        if (rst_i || (wr_test && sel_me)) begin
          prbs_reg <= `JFST_PRBS_SEED;
          ramp_reg <= 16'h0000;
          tog_reg  <= 1'b0;
          once_reg <= 1'b0;
        end else begin
          prbs_reg <= prbs_nx[30:0];
          ramp_reg <= ramp_reg + 16'h0001;
          tog_reg  <= ~tog_reg;
          once_reg <= 1'b1;
        end
      end

      // ------------------------------------------------------------------
      // Injection and lane routing
      // ------------------------------------------------------------------
      // test source replaces converter
      assign test_on   = (src != `JFST_SRC_CONV);
      assign at_serdes = test_on & (inj == `JFST_INJ_SERDES);
      assign at_route  = test_on & (inj == `JFST_INJ_ROUTE);
      assign at_front  = test_on & ~at_serdes & ~at_route;
      assign front = at_front ? gen : conv_data_i[i*16 +: 16];

      always @* begin
        routed = 16'h0000;
        for (j = 0; j < 4; j = j + 1) begin
          if (cfg_reg[`JFST_CFG_MANUAL])
            routed[j*4 +: 4] =
              front[cfg_reg[`JFST_CFG_ROUTE_LSB + j*2 +: 2]*4 +: 4];
          else
            routed[j*4 +: 4] = front[j*4 +: 4];
        end
      end

      always @(posedge clk_i) begin
        if (rst_i) begin
          mid_reg  <= 16'h0000;
          lane_reg <= 16'h0000;
        end else begin
          mid_reg  <= at_route ? gen : routed;
          lane_reg <= at_serdes ? gen : mid_reg;
        end
      end

      assign cfg_all[i*32 +: 32]   = cfg_wide;
      assign test_all[i*32 +: 32]  = test_reg;
      assign stat_all[i*4 +: 4]    = {sync_lvl_reg, cgs_reg,
                                      perr_reg, aligned_reg};
      assign lane_data_o[i*16 +: 16] = lane_reg;
      assign lmfc_pulse_o[i]  = lmfc_p_reg;
      assign lemc_pulse_o[i]  = lemc_p_reg;
      assign cgs_enable_o[i]  = cgs_reg;
      assign bit_repeat_o[i]  = brep_reg;
      assign oversample_o[i]  = ovs_reg;
    end
  endgenerate

endmodule // jfst_framer_ctrl

// >>> dv/jfst_framer_ctrl_properties.sv
// Purpose: Port assertions for the framer control block
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound to every instance of the design
`timescale 1ns/100ps
module jfst_framer_ctrl_props #(
  parameter NFR = 3
) (
  input logic           clk_i,
  input logic           rst_i,
  input logic           wb_cyc_i,
  input logic           wb_stb_i,
  input logic           wb_ack_o,
  input logic           sysref_pin_i,
  input logic           mcs_done_i,
  input logic [NFR-1:0] pad_required_i,
  input logic [NFR-1:0] lmfc_pulse_o,
  input logic [NFR-1:0] lemc_pulse_o,
  input logic [NFR-1:0] bit_repeat_o,
  input logic [NFR-1:0] oversample_o
);
  logic pin_reg;
  logic seen_reg;

  // ------------------------------------------------------------------
  // Remembers an alignment edge arriving while the sequencer is done
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    pin_reg  <= sysref_pin_i;
    seen_reg <= rst_i ? 1'b0
                : seen_reg | (sysref_pin_i & ~pin_reg & mcs_done_i);
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_prompt: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_pad_follow: assert property (!$past(rst_i) |-> ((bit_repeat_o | oversample_o) == $past(pad_required_i)))
    else $error("padding method does not follow padding need");
  a_pad_excl: assert property ((bit_repeat_o & oversample_o) == '0)
    else $error("bit repeat and oversample both active");
  a_lmfc_space: assert property (lmfc_pulse_o[0] |=> !lmfc_pulse_o[0] [*3])
    else $error("multiframe pulses too close");
  a_lemc_on_lmfc: assert property (|lemc_pulse_o |-> ((lemc_pulse_o & ~lmfc_pulse_o) == '0))
    else $error("multiblock pulse off a multiframe boundary");
  a_mcs_hold: assert property (!seen_reg |-> (lmfc_pulse_o == '0))
    else $error("multiframe pulse before any admitted alignment edge");
endmodule // jfst_framer_ctrl_props

bind jfst_framer_ctrl jfst_framer_ctrl_props #(.NFR(NFR)) props_u (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .sysref_pin_i(sysref_pin_i),
  .mcs_done_i(mcs_done_i), .pad_required_i(pad_required_i),
  .lmfc_pulse_o(lmfc_pulse_o), .lemc_pulse_o(lemc_pulse_o),
  .bit_repeat_o(bit_repeat_o), .oversample_o(oversample_o));

// >>> dv/jfst_deframer_model.sv
// Purpose: Far-end deframer model: drives sync pins, takes lanes
// Assumes: Differential sync is handed over as a resolved level
// Notes:   Sync levels follow the bench request one cycle later
`timescale 1ns/100ps
module jfst_deframer_model (
  input  logic        clk_i,
  input  logic [2:0]  cmos_req_i,
  input  logic [2:0]  lvds_req_i,
  input  logic [47:0] lane_data_i,
  output logic [2:0]  sync_cmos_o = 3'h0,
  output logic [2:0]  sync_lvds_o = 3'h0,
  output logic [47:0] lanes_seen_o
);
  always_ff @(posedge clk_i) begin
    sync_cmos_o  <= cmos_req_i;
    sync_lvds_o  <= lvds_req_i;
    lanes_seen_o <= lane_data_i;
  end
endmodule // jfst_deframer_model

// >>> dv/testbench.sv
// Purpose: Self-checking bench for the framer control block
// Assumes: Wishbone classic master, short multiframe periods
// Notes:   All framers selected unless a scenario says otherwise
`timescale 1ns/100ps
module testbench;
  logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000, rdat, q;
  logic        ack, sysref = 0, multichip_sync_sequencer = 0;
  logic [2:0]  link = 3'h0, padreq = 3'h0, scm = 3'h0, slv = 3'h0;
  logic [2:0]  s_cmos, s_lvds, lmfc, lemc, cgs, brep, ovs;
  logic [47:0] conv = {3{16'h5A5A}}, lane;
  logic [15:0] a;
  int          n_fail = 0, cmp_count = 0;

  initial forever #2 clk_i = ~clk_i;

  jfst_framer_ctrl #(.LMFC_PERIOD(8'h04), .LEMC_PERIOD(8'h08)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .sysref_pin_i(sysref),
    .mcs_done_i(multichip_sync_sequencer), .link_up_i(link), .pad_required_i(padreq),
    .sync_cmos_i(s_cmos), .sync_lvds_i(s_lvds), .conv_data_i(conv),
    .lane_data_o(lane), .lmfc_pulse_o(lmfc), .lemc_pulse_o(lemc),
    .cgs_enable_o(cgs), .bit_repeat_o(brep), .oversample_o(ovs));

  jfst_deframer_model mdl_u (.clk_i(clk_i), .cmos_req_i(scm),
    .lvds_req_i(slv), .lane_data_i(lane), .sync_cmos_o(s_cmos),
    .sync_lvds_o(s_lvds), .lanes_seen_o());

  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task chk(input logic [47:0] s, input logic [47:0] e);
    cmp_count++;
    if (s !== e) begin
      n_fail++;
      $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task cyc_n(input int k);
    repeat (k) @(posedge clk_i);
  endtask

  task wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= ad;
    wdat <= d;
    sel <= 4'hF;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat;
    cyc <= 0;
    stb <= 0;
    if (n >= 50) begin
      n_fail++;
      summarize();
    end
  endtask

  task pulse;
    sysref <= 1;
    cyc_n(3);
    sysref <= 0;
    cyc_n(7);
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task t_reset;
    wb(0, 8'h0C, 0);
    chk(q, 3'h7);
    wb(0, 8'h00, 0);
    chk(q, 3'h7);
    wb(0, 8'h14, 0);
    chk(q, 0);
    chk(cgs, 3'h7);
  endtask

  task t_pad;
    padreq <= 3'h7;
    wb(1, 8'h04, 32'h0000_0001);
    cyc_n(3);
    chk({brep, ovs}, 6'h07);
    wb(1, 8'h00, 32'h0000_0001);
    wb(1, 8'h04, 32'h0000_0000);
    cyc_n(3);
    chk({brep, ovs}, 6'h0E);
    wb(1, 8'h00, 32'h0000_0007);
  endtask

  task t_route;
    logic [31:0] cf [5] = '{32'h0000_006C, 32'h0000_006E, 32'h0000_006E,
                            32'h0000_006E, 32'h0000_006E};
    logic [31:0] ts [5] = '{32'h0000_0000, 32'h0000_0000, 32'h1234_0009,
                            32'h1234_0019, 32'h1234_0029};
    logic [15:0] ex [5] = '{16'h5A5A, 16'hA5A5, 16'h4321, 16'h1234,
                            16'h1234};
    for (int i = 0; i < 5; i++) begin
      wb(1, 8'h04, cf[i]);
      wb(1, 8'h08, ts[i]);
      cyc_n(3);
      chk(lane[15:0], ex[i]);
    end
    wb(1, 8'h04, 32'h0000_0000);
  endtask

  task t_sources;
    for (int c = 1; c < 11; c++) begin
      wb(1, 8'h08, 32'h1234_0000 | c);
      cyc_n(4);
      a = lane[15:0];
      cyc_n(1);
      chk(a != 16'h5A5A, 1'b1);
      if (c == 1) chk(a, 16'hAAAA);
      if (c == 2) chk(a ^ lane[15:0], 16'hFFFF);
      if (c > 2 && c < 9) chk(a != lane[15:0], 1'b1);
      if (c == 9) chk(lane[15:0], 16'h1234);
      if (c == 10) chk(lane[15:0], 16'h0000);
    end
    wb(1, 8'h08, 32'h0000_0000);
  endtask

  task t_sync;
    logic [31:0] cf [5] = '{32'h0010_0400, 32'h0010_0C00, 32'h0000_0000,
                            32'h0010_0000, 32'h0020_0000};
    logic        ex [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
    scm <= 3'h5;
    slv <= 3'h2;
    for (int i = 0; i < 5; i++) begin
      wb(1, 8'h04, cf[i]);
      cyc_n(4);
      wb(0, 8'h10, 0);
      chk(q[3], ex[i]);
    end
  endtask

  task t_align;
    pulse();
    wb(0, 8'h10, 0);
    chk(q[11:0] & 12'h333, 12'h000);
    wb(1, 8'h04, 32'h0009_6000);
    link <= 3'h4;
    wb(1, 8'h0C, 32'h0000_0007);
    multichip_sync_sequencer <= 1;
    pulse();
    wb(0, 8'h10, 0);
    chk(q[11:0] & 12'h333, 12'h000);
    wb(1, 8'h0C, 32'h0000_0105);
    pulse();
    pulse();
    wb(0, 8'h10, 0);
    chk(q[11:0] & 12'h333, 12'h000);
    pulse();
    pulse();
    wb(0, 8'h10, 0);
    chk(q[11:0] & 12'h333, 12'h003);
    chk(cgs, 3'h1);
    wb(1, 8'h10, 32'h0000_0002);
    wb(0, 8'h10, 0);
    chk(q[11:0] & 12'h333, 12'h001);
  endtask

  task t_relink;
    int nl, ne;
    wb(1, 8'h04, 32'h0000_1000);
    link <= 3'h5;
    cyc_n(2);
    wb(0, 8'h10, 0);
    chk(q[11:0] & 12'h333, 12'h000);
    pulse();
    wb(0, 8'h10, 0);
    chk(q[11:0] & 12'h333, 12'h101);
    nl = 0;
    ne = 0;
    repeat (16) begin
      @(posedge clk_i);
      nl += lmfc[0];
      ne += lemc[0];
    end
    chk(nl, 4);
    chk(ne, 2);
  endtask

  initial begin
    #200000;
    n_fail++;
    summarize();
  end

  initial begin
    cyc_n(5);
    rst_i <= 0;
    t_reset();
    t_pad();
    t_route();
    t_sources();
    t_sync();
    t_align();
    t_relink();
    summarize();
  end
endmodule // testbench
